// ==== cpcc_pkg.sv ====
// package of offsets, fields and reset values for the cache power and clock block
package cpcc_pkg;
  // ----------------------------------------
  // register word offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CPCC_AUX_CTRL_OFS = 8'h00;
  localparam logic [7:0] CPCC_PREFETCH_OFS = 8'h04;
  localparam logic [7:0] CPCC_POWER_MODE_OFS = 8'h08;
  localparam logic [7:0] CPCC_CACHE_CTRL_OFS = 8'h0c;
  localparam logic [7:0] CPCC_IDENT_OFS = 8'h10;
  localparam logic [7:0] CPCC_FILTER_OFS = 8'h14;
  localparam logic [7:0] CPCC_LATENCY_OFS = 8'h18;
  localparam logic [7:0] CPCC_STATUS_OFS = 8'h1c;
  localparam logic [7:0] CPCC_ACTIVITY_OFS = 8'h20;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CPCC_INSTR_PF_BIT = 29;
  localparam int CPCC_DATA_PF_BIT = 28;
  localparam int CPCC_AUX_ASSOC_BIT = 16;
  localparam int CPCC_AUX_WAY_LSB = 17;
  localparam int CPCC_GATING_BIT = 1;
  localparam int CPCC_STANDBY_BIT = 0;
  localparam int CPCC_FILT_END_LSB = 16;
  localparam int CPCC_FILT_START_LSB = 4;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] CPCC_AUX_RESET = 32'h0000_0000;
  localparam logic [31:0] CPCC_PREFETCH_RESET = 32'h0000_0000;
  localparam logic [1:0] CPCC_POWER_RESET = 2'h0;
  localparam logic [17:0] CPCC_LATENCY_RESET = 18'h00000;
  // quiet count reached before idle; the block reports idle after the third quiet cycle
  localparam logic [1:0] CPCC_IDLE_SETTLE = 2'h2;
  // cache id type
  typedef logic [5:0] cpcc_ident_t;
endpackage

// ==== cpcc_top.sv ====
// power mode, clock gating and strap configuration of a level 2 cache controller
// ----------------------------------------
// Summary of operation
// - prefetch enables seen in two registers
// - auxiliary writes ignored while cache enabled
// - prefetch register writable while cache enabled
// - power mode: gating bit1, standby bit0
// - active-low reset initialises everything
// - halt request answered by halted flag
// - idle output high with no activity
// - per-port input sample enables
// - per-port output update enables
// - four data array clocks and enables
// - tag array clock and enable
// - byte order strap caught in the first cycle after reset release
// - filter enable strap gives reset value
// - filter bounds loaded from straps
// - registers decoded against window base
// - data array latencies output
// - tag array latencies output
// - associativity and way size in auxiliary
// - cache id visible in register
// ----------------------------------------
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
module cpcc_top
  import cpcc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [19:0] reg_window_sel,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // power handshake
  input wire logic clock_halt_request,
  output logic clock_halted_flag,
  output logic idle,
  // activity from the cache datapath
  input wire logic [3:0] port_request,
  // per port clock enables
  input wire logic slave0_input_sample_enable,
  input wire logic slave1_input_sample_enable,
  input wire logic master0_input_sample_enable,
  input wire logic master1_input_sample_enable,
  input wire logic slave0_output_update_enable,
  input wire logic slave1_output_update_enable,
  input wire logic master0_output_update_enable,
  input wire logic master1_output_update_enable,
  output logic [3:0] port_sample_strobe,
  output logic [3:0] port_update_strobe,
  // ram clocking
  input wire logic data_array_clk_enable_in,
  input wire logic tag_array_clk_enable_in,
  output logic [3:0] data_array_clk_out,
  output logic [3:0] data_array_clk_enable_out,
  output logic tag_array_clk_out,
  output logic tag_array_clk_enable_out,
  // configuration straps
  input wire logic [19:0] register_window_base,
  input wire logic register_byte_order_strap,
  input wire logic filter_enable_strap,
  input wire logic [11:0] filter_low_bound_strap,
  input wire logic [11:0] filter_high_bound_strap,
  input wire logic associativity_strap,
  input wire logic [2:0] way_capacity_strap,
  input wire cpcc_ident_t controller_ident_input,
  input wire logic scan_shift_enable,
  // configuration outputs
  output logic big_endian_regs,
  output logic filter_enable,
  output logic [2:0] data_array_read_latency,
  output logic [2:0] data_array_setup_latency,
  output logic [2:0] data_array_write_latency,
  output logic [2:0] tag_array_read_latency,
  output logic [2:0] tag_array_setup_latency,
  output logic [2:0] tag_array_write_latency
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum {CPCC_RUN, CPCC_DRAIN, CPCC_HALTED} cpcc_state_t;
  cpcc_state_t state_reg, state_next;
  logic [31:0] aux_reg, aux_next;
  logic instr_pf_reg, data_pf_reg;
  logic [1:0] power_reg;
  logic cache_en_reg;
  logic [17:0] latency_reg;
  logic [11:0] filt_start_reg, filt_end_reg;
  logic filt_en_reg, big_end_reg, strap_done_reg;
  logic [31:0] rdata_reg;
  logic [1:0] quiet_reg;
  logic idle_reg, halted_reg, gate_reg;
  logic [3:0] req_s1_reg, req_s2_reg, req_s3_reg, req_stable_reg;
  logic [3:0] sample_reg, update_reg;
  logic [3:0] data_clk_reg, data_en_reg;
  logic tag_clk_reg, tag_en_reg;
  logic halt_s1_reg, halt_s2_reg, halt_s3_reg, halt_reg;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // window match against the base strap, scan shift blocks writes
  wire in_window = (reg_window_sel == register_window_base);
  wire wr_ok = reg_write && in_window && !scan_shift_enable;
  wire wr_aux = wr_ok && hit(reg_addr, CPCC_AUX_CTRL_OFS) && !cache_en_reg;
  wire wr_pf = wr_ok && hit(reg_addr, CPCC_PREFETCH_OFS);
  wire wr_pwr = wr_ok && hit(reg_addr, CPCC_POWER_MODE_OFS);
  wire wr_cen = wr_ok && hit(reg_addr, CPCC_CACHE_CTRL_OFS);
  wire wr_lat = wr_ok && hit(reg_addr, CPCC_LATENCY_OFS);
  wire wr_filt = wr_ok && hit(reg_addr, CPCC_FILTER_OFS);
  // auxiliary view: strap fields forced, prefetch bits shared
  wire [31:0] aux_view = {aux_reg[31:30], instr_pf_reg, data_pf_reg, aux_reg[27:20],
                          way_capacity_strap, associativity_strap, aux_reg[15:0]};
  wire [31:0] pf_view = {2'h0, instr_pf_reg, data_pf_reg, 28'h0000000};
  wire [31:0] filt_view = {3'h0, filt_en_reg, filt_end_reg, filt_start_reg, 4'h0};
  wire [31:0] stat_view = {28'h0000000, gate_reg, big_end_reg, halted_reg, idle_reg};
  // read mux; unmapped or outside window reads zero
  wire [31:0] rd_mux =
    !in_window ? 32'h0000_0000 :
    hit(reg_addr, CPCC_AUX_CTRL_OFS) ? aux_view :
    hit(reg_addr, CPCC_PREFETCH_OFS) ? pf_view :
    hit(reg_addr, CPCC_POWER_MODE_OFS) ? {30'h0, power_reg} :
    hit(reg_addr, CPCC_CACHE_CTRL_OFS) ? {31'h0, cache_en_reg} :
    hit(reg_addr, CPCC_IDENT_OFS) ? {26'h0, controller_ident_input} :
    hit(reg_addr, CPCC_FILTER_OFS) ? filt_view :
    hit(reg_addr, CPCC_LATENCY_OFS) ? {14'h0, latency_reg} :
    hit(reg_addr, CPCC_STATUS_OFS) ? stat_view :
    hit(reg_addr, CPCC_ACTIVITY_OFS) ? {28'h0, req_stable_reg} : 32'h0000_0000;
  // byte order strap swaps register data lanes
  wire [31:0] rd_swapped = big_end_reg ? {rd_mux[7:0], rd_mux[15:8], rd_mux[23:16], rd_mux[31:24]} : rd_mux;
  wire [31:0] wd = big_end_reg ? {reg_wdata[7:0], reg_wdata[15:8], reg_wdata[23:16], reg_wdata[31:24]} : reg_wdata;
  assign aux_next = wr_aux ? wd : aux_reg;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // all control state cleared by the global reset
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aux_reg <= CPCC_AUX_RESET;
      instr_pf_reg <= 1'b0;
      data_pf_reg <= 1'b0;
      power_reg <= CPCC_POWER_RESET;
      cache_en_reg <= 1'b0;
      latency_reg <= CPCC_LATENCY_RESET;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      aux_reg <= aux_next;
      if (wr_pf || wr_aux)
      begin
        instr_pf_reg <= wd[CPCC_INSTR_PF_BIT];
        data_pf_reg <= wd[CPCC_DATA_PF_BIT];
      end
      if (wr_pwr)
        power_reg <= wd[1:0];
      if (wr_cen)
        cache_en_reg <= wd[0];
      if (wr_lat)
        latency_reg <= wd[17:0];
      rdata_reg <= reg_read ? rd_swapped : 32'h0000_0000;
    end
  end

  // straps caught in the first cycle after reset release, not under reset
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_done_reg <= 1'b0;
      big_end_reg <= 1'b0;
      filt_en_reg <= 1'b0;
      filt_start_reg <= 12'h000;
      filt_end_reg <= 12'h000;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      big_end_reg <= register_byte_order_strap;
      filt_en_reg <= filter_enable_strap;
      filt_start_reg <= filter_low_bound_strap;
      filt_end_reg <= filter_high_bound_strap;
    end
    else if (wr_filt)
    begin
      filt_en_reg <= wd[28];
      filt_end_reg <= wd[27:16];
      filt_start_reg <= wd[15:4];
    end
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // three stages; a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_s1_reg <= 4'h0;
      req_s2_reg <= 4'h0;
      req_s3_reg <= 4'h0;
      req_stable_reg <= 4'h0;
      halt_s1_reg <= 1'b0;
      halt_s2_reg <= 1'b0;
      halt_s3_reg <= 1'b0;
      halt_reg <= 1'b0;
    end
    else
    begin
      req_s1_reg <= port_request;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      req_stable_reg <= (req_s2_reg & req_s3_reg) | (req_stable_reg & (req_s2_reg | req_s3_reg));
      halt_s1_reg <= clock_halt_request;
      halt_s2_reg <= halt_s1_reg;
      halt_s3_reg <= halt_s2_reg;
      if (halt_s2_reg == halt_s3_reg)
        halt_reg <= halt_s3_reg;
    end
  end

  // ----------------------------------------
  // idle and halt handshake
  // ----------------------------------------
  // pending requests in synchroniser stages two and three or the stable value count as activity
  wire busy = |(req_s2_reg | req_s3_reg | req_stable_reg);
  wire [1:0] quiet_next = busy ? 2'h0 : (quiet_reg == CPCC_IDLE_SETTLE) ? quiet_reg : quiet_reg + 2'h1;
  wire idle_next = !busy && (quiet_reg == CPCC_IDLE_SETTLE);

  // halt only granted once idle; any withdrawal drops it at once
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CPCC_RUN: if (halt_reg) state_next = CPCC_DRAIN;
      CPCC_DRAIN: if (!halt_reg) state_next = CPCC_RUN; else if (idle_reg && idle_next) state_next = CPCC_HALTED;
      CPCC_HALTED: if (!halt_reg) state_next = CPCC_RUN; else if (busy) state_next = CPCC_DRAIN;
      default: state_next = CPCC_RUN;
    endcase
  end

  // gating follows idle when enabled; standby also gates during halt
  wire gate_next = (power_reg[CPCC_GATING_BIT] && idle_next) ||
                   (power_reg[CPCC_STANDBY_BIT] && state_next == CPCC_HALTED);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= CPCC_RUN;
      quiet_reg <= 2'h0;
      idle_reg <= 1'b0;
      halted_reg <= 1'b0;
      gate_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      quiet_reg <= quiet_next;
      idle_reg <= idle_next;
      halted_reg <= (state_next == CPCC_HALTED);
      gate_reg <= gate_next && !busy;
    end
  end

  // ----------------------------------------
  // port enables and ram clocking
  // ----------------------------------------
  // port strobes qualified by per-port enables, suppressed while halted
  wire [3:0] in_en = {master1_input_sample_enable, master0_input_sample_enable,
                      slave1_input_sample_enable, slave0_input_sample_enable};
  wire [3:0] out_en = {master1_output_update_enable, master0_output_update_enable,
                       slave1_output_update_enable, slave0_output_update_enable};
  wire run = (state_next != CPCC_HALTED);
  // sampling continues when gated so an arriving request is not lost
  wire [3:0] sample_next = in_en & {4{run}};
  wire [3:0] update_next = out_en & {4{run && !gate_next}};
  wire ram_on = run && !gate_next;
  // ram clock is a registered divided enable, one bank per bit
  wire [3:0] data_clk_next = {4{data_array_clk_enable_in && ram_on && !data_clk_reg[0]}};
  wire tag_clk_next = tag_array_clk_enable_in && ram_on && !tag_clk_reg;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sample_reg <= 4'h0;
      update_reg <= 4'h0;
      data_clk_reg <= 4'h0;
      data_en_reg <= 4'h0;
      tag_clk_reg <= 1'b0;
      tag_en_reg <= 1'b0;
    end
    else
    begin
      sample_reg <= sample_next;
      update_reg <= update_next;
      data_clk_reg <= data_clk_next;
      data_en_reg <= {4{data_array_clk_enable_in && ram_on}};
      tag_clk_reg <= tag_clk_next;
      tag_en_reg <= tag_array_clk_enable_in && ram_on;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rdata_reg;
  assign clock_halted_flag = halted_reg;
  assign idle = idle_reg;
  assign port_sample_strobe = sample_reg;
  assign port_update_strobe = update_reg;
  assign data_array_clk_out = data_clk_reg;
  assign data_array_clk_enable_out = data_en_reg;
  assign tag_array_clk_out = tag_clk_reg;
  assign tag_array_clk_enable_out = tag_en_reg;
  assign big_endian_regs = big_end_reg;
  assign filter_enable = filt_en_reg;
  // latency fields: data read, setup, write then tag
  assign data_array_read_latency = latency_reg[2:0];
  assign data_array_setup_latency = latency_reg[5:3];
  assign data_array_write_latency = latency_reg[8:6];
  assign tag_array_read_latency = latency_reg[11:9];
  assign tag_array_setup_latency = latency_reg[14:12];
  assign tag_array_write_latency = latency_reg[17:15];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  aux_locked_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cache_en_reg && reg_write) |=> $stable(aux_reg)) else $error("aux changed while enabled");
  pf_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_pf |=> (instr_pf_reg == $past(wd[29]))) else $error("prefetch write lost");
  pf_views_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_aux |=> ({instr_pf_reg, data_pf_reg} == $past(wd[29:28]))) else $error("prefetch views differ");
  power_res_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_read && in_window && hit(reg_addr, CPCC_POWER_MODE_OFS) && !big_end_reg) |=> (reg_rdata[31:2] == 30'h0))
    else $error("power reserved bits set");
  halt_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(clock_halted_flag) |-> ($past(idle_reg) && $past(halt_reg))) else $error("halted while busy");
  halt_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (clock_halted_flag && !halt_reg) |=> !clock_halted_flag) else $error("halt not withdrawn");
  idle_busy_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (|req_stable_reg) |=> !idle) else $error("idle while active");
  sample_halt_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    clock_halted_flag |-> (port_sample_strobe == 4'h0)) else $error("sampling while halted");
  gate_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (gate_reg && !clock_halted_flag) |-> ##0 (data_array_clk_enable_out == 4'h0)) else $error("ram on while gated");
  strap_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!strap_done_reg) |=> (big_end_reg == $past(register_byte_order_strap))) else $error("strap missed");
  halt_cov_c: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(clock_halted_flag));
  gate_cov_c: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(gate_reg));
  aux_cov_c: cover property (@(posedge core_clk) disable iff (!reset_n) wr_aux);
endmodule

// ==== cpcc_power_partner.sv ====
// model of the clock, power and reset controller that faces the block
module cpcc_power_partner
(
  // clock
  input wire logic core_clk,
  // commands from the bench
  input wire logic halt_cmd,
  input wire logic [1:0] enable_mode,
  input wire logic ram_enable_cmd,
  // towards the block
  output logic clock_halt_request,
  output logic [3:0] input_enables,
  output logic [3:0] output_enables,
  output logic ram_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic phase_reg = 1'b0;
  wire rate_on;
  // request is a plain level, held until the bench withdraws it
  always_ff @(posedge core_clk)
  begin
    clock_halt_request <= halt_cmd;
    phase_reg <= ~phase_reg;
  end
  // mode 0 ports off, 1 full rate, 2 half rate of the main clock
  assign rate_on = (enable_mode == 2'h1) || (enable_mode == 2'h2 && phase_reg);
  assign input_enables = rate_on ? 4'hf : 4'h0;
  assign output_enables = rate_on ? 4'hf : 4'h0;
  assign ram_enable = ram_enable_cmd;
endmodule

// ==== tb_cache_power_clock_config.sv ====
// self-checking bench for the cache power, clock and strap block
module tb_cache_power_clock_config;
  import cpcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [19:0] reg_window_sel = 20'h0, base = 20'habcde;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [3:0] port_request = 4'h0, in_en, out_en, port_sample_strobe, port_update_strobe;
  logic [3:0] data_array_clk_out, data_array_clk_enable_out;
  logic halt_cmd = 1'b0, ram_cmd = 1'b0, halt_req, ram_en, scan = 1'b0;
  logic [1:0] mode = 2'h1;
  logic order = 1'b0, filt_en = 1'b1, assoc = 1'b1, clock_halted_flag, idle;
  logic [11:0] filt_lo = 12'h123, filt_hi = 12'h456;
  logic [2:0] way = 3'h5;
  cpcc_ident_t ident = 6'h2a;
  logic tag_array_clk_out, tag_array_clk_enable_out, big_endian_regs, filter_enable;
  logic [2:0] drl, dsl, dwl, trl, tsl, twl;
  int fails = 0, samples_checked = 0, cycles = 0;
  // ----------------------------------------
  // clock, partner and design
  // ----------------------------------------
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end
  cpcc_power_partner u_partner (.core_clk(core_clk), .halt_cmd(halt_cmd), .enable_mode(mode),
    .ram_enable_cmd(ram_cmd), .clock_halt_request(halt_req), .input_enables(in_en),
    .output_enables(out_en), .ram_enable(ram_en));
  cpcc_top u_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_window_sel(reg_window_sel),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .clock_halt_request(halt_req), .clock_halted_flag(clock_halted_flag),
    .idle(idle), .port_request(port_request), .slave0_input_sample_enable(in_en[0]),
    .slave1_input_sample_enable(in_en[1]), .master0_input_sample_enable(in_en[2]),
    .master1_input_sample_enable(in_en[3]), .slave0_output_update_enable(out_en[0]),
    .slave1_output_update_enable(out_en[1]), .master0_output_update_enable(out_en[2]),
    .master1_output_update_enable(out_en[3]), .port_sample_strobe(port_sample_strobe),
    .port_update_strobe(port_update_strobe), .data_array_clk_enable_in(ram_en),
    .tag_array_clk_enable_in(ram_en), .data_array_clk_out(data_array_clk_out),
    .data_array_clk_enable_out(data_array_clk_enable_out), .tag_array_clk_out(tag_array_clk_out),
    .tag_array_clk_enable_out(tag_array_clk_enable_out), .register_window_base(base),
    .register_byte_order_strap(order), .filter_enable_strap(filt_en), .filter_low_bound_strap(filt_lo),
    .filter_high_bound_strap(filt_hi), .associativity_strap(assoc), .way_capacity_strap(way),
    .controller_ident_input(ident), .scan_shift_enable(scan), .big_endian_regs(big_endian_regs),
    .filter_enable(filter_enable), .data_array_read_latency(drl), .data_array_setup_latency(dsl),
    .data_array_write_latency(dwl), .tag_array_read_latency(trl), .tag_array_setup_latency(tsl),
    .tag_array_write_latency(twl));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize;
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // big-endian register view swaps bytes both ways
  function automatic logic [31:0] view(input logic [31:0] v);
    return order ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
  endfunction
  task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    reg_addr <= addr;
    reg_wdata <= view(data);
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic check_rd(input string name, input logic [7:0] addr, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= addr;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    check(name, reg_rdata, view(exp));
  endtask
  task automatic apply_reset;
    @(posedge core_clk);
    reset_n <= 1'b0;
    reg_window_sel <= base;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask
  // polls a flag for a bounded number of cycles
  task automatic wait_for(ref logic sig, input logic lvl, input int limit);
    for (int n = 0; n < limit && sig !== lvl; n++)
      @(posedge core_clk);
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_straps;
    check("big_endian_regs", big_endian_regs, order);
    check("filter_enable", filter_enable, filt_en);
    check_rd("filter", CPCC_FILTER_OFS, {3'h0, filt_en, filt_hi, filt_lo, 4'h0});
    check_rd("aux", CPCC_AUX_CTRL_OFS, {12'h0, way, assoc, 16'h0});
    check_rd("ident", CPCC_IDENT_OFS, {26'h0, ident});
    check_rd("power_reset", CPCC_POWER_MODE_OFS, 32'h0);
    check("latency_reset", {twl, tsl, trl, dwl, dsl, drl}, 32'h0);
  endtask
  task automatic test_power;
    scan <= 1'b1; // shift in progress blocks writes
    reg_wr(CPCC_POWER_MODE_OFS, 32'hffff_ffff);
    scan <= 1'b0;
    check_rd("power_scan", CPCC_POWER_MODE_OFS, 32'h0);
    reg_wr(CPCC_POWER_MODE_OFS, 32'hffff_ffff);
    check_rd("power_set", CPCC_POWER_MODE_OFS, 32'h3);
    reg_wr(CPCC_POWER_MODE_OFS, 32'h0);
    check_rd("power_clr", CPCC_POWER_MODE_OFS, 32'h0);
  endtask
  task automatic test_prefetch;
    logic [31:0] aux0;
    aux0 = {12'h0, way, assoc, 16'h0};
    reg_wr(CPCC_AUX_CTRL_OFS, 32'h3000_0000);
    check_rd("pf_via_aux", CPCC_PREFETCH_OFS, 32'h3000_0000);
    reg_wr(CPCC_CACHE_CTRL_OFS, 32'h1);
    reg_wr(CPCC_AUX_CTRL_OFS, 32'h0);
    check_rd("aux_locked", CPCC_AUX_CTRL_OFS, aux0 | 32'h3000_0000);
    reg_wr(CPCC_PREFETCH_OFS, 32'h1000_0000);
    check_rd("pf_enabled", CPCC_PREFETCH_OFS, 32'h1000_0000);
    check_rd("aux_view", CPCC_AUX_CTRL_OFS, aux0 | 32'h1000_0000);
    reg_wr(CPCC_CACHE_CTRL_OFS, 32'h0);
  endtask
  task automatic test_window;
    reg_window_sel <= base ^ 20'h8_0001;
    reg_wr(CPCC_POWER_MODE_OFS, 32'h3);
    check_rd("outside_rd", CPCC_POWER_MODE_OFS, 32'h0);
    reg_window_sel <= base;
    check_rd("outside_wr", CPCC_POWER_MODE_OFS, 32'h0);
    check_rd("unmapped", 8'h3c, 32'h0);
  endtask
  task automatic test_latency;
    reg_wr(CPCC_LATENCY_OFS, 32'h0003_58d1);
    @(posedge core_clk);
    #1;
    check("data_latency", {dwl, dsl, drl}, 32'h0d1);
    check("tag_latency", {twl, tsl, trl}, 32'h1ac);
  endtask
  task automatic test_ports;
    logic [3:0] a, b;
    @(posedge core_clk);
    ram_cmd <= 1'b1;
    mode <= 2'h2;
    repeat (3) @(posedge core_clk);
    #1;
    a = port_sample_strobe;
    b = data_array_clk_out;
    @(posedge core_clk);
    #1;
    check("sample_half_rate", a ^ port_sample_strobe, 32'hf);
    check("data_clk_toggle", b ^ data_array_clk_out, 32'hf);
    mode <= 2'h1;
    repeat (2) @(posedge core_clk);
    #1;
    check("update_strobe", port_update_strobe, 32'hf);
    check("data_clk_en", data_array_clk_enable_out, 32'hf);
    check("tag_clk_en", tag_array_clk_enable_out, 32'h1);
    a[0] = tag_array_clk_out;
    @(posedge core_clk);
    #1;
    check("tag_clk_toggle", tag_array_clk_out, {31'h0, ~a[0]});
  endtask
  task automatic test_gating;
    reg_wr(CPCC_POWER_MODE_OFS, 32'h2);
    wait_for(idle, 1'b1, 10);
    repeat (3) @(posedge core_clk);
    #1;
    check("gated_data_en", data_array_clk_enable_out, 32'h0);
    check("gated_update", port_update_strobe, 32'h0);
    check("sample_kept", port_sample_strobe, 32'hf);
    port_request <= 4'h4;
    wait_for(idle, 1'b0, 6);
    check("busy_idle", idle, 32'h0);
    check_rd("activity", CPCC_ACTIVITY_OFS, 32'h4);
    repeat (3) @(posedge core_clk);
    #1;
    check("ungated_update", port_update_strobe, 32'hf);
    port_request <= 4'h0;
    ram_cmd <= 1'b0;
    reg_wr(CPCC_POWER_MODE_OFS, 32'h0);
    repeat (2) @(posedge core_clk);
    #1;
    check("ram_en_off", {tag_array_clk_enable_out, data_array_clk_enable_out}, 32'h0);
  endtask
  task automatic test_halt;
    @(posedge core_clk);
    port_request <= 4'h2;
    halt_cmd <= 1'b1;
    repeat (12) @(posedge core_clk);
    #1;
    check("halt_while_busy", clock_halted_flag, 32'h0);
    port_request <= 4'h0;
    wait_for(clock_halted_flag, 1'b1, 12);
    check("halted", clock_halted_flag, 32'h1);
    check("idle_halted", idle, 32'h1);
    check("sample_halted", port_sample_strobe, 32'h0);
    check_rd("status_halted", CPCC_STATUS_OFS, 32'h3);
    halt_cmd <= 1'b0;
    wait_for(clock_halted_flag, 1'b0, 8);
    check("halt_released", clock_halted_flag, 32'h0);
  endtask
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    apply_reset();
    test_straps();
    test_power();
    test_prefetch();
    test_window();
    test_latency();
    test_ports();
    test_gating();
    test_halt();
    // second run with the other strap set and big-endian registers
    {order, filt_en, assoc, way, ident} = {1'b1, 1'b0, 1'b0, 3'h2, 6'h15};
    {base, filt_lo, filt_hi} = {20'h12345, 12'hfed, 12'h0ba};
    apply_reset();
    test_straps();
    test_power();
    summarize();
  end
endmodule
